// ==== hdl/logical_device_config_regs.sv ====
// How it works
// - pp mode field bits 2:0 selects port mode, resets to printer 100
// - bits 6:3 hold ecp fifo threshold, reset 0111
// - interrupt type 1: low pulse, then line released to high impedance
// - interrupt type 0: interrupt follows acknowledge in epp or non-fifo ecp submodes
// - interrupt type 0 with ecp, test or fifo mode: level interrupt
// - interrupt type ignored in printer and standard modes
// - drive mux field routes floppy drives onto parallel pins
// - uart mode bit 0 enables midi, reset 0
// - uart mode bit 1 enables high speed, reset 0
// - first uart bit 7 selects shared interrupt
// - shared with two lines: both lines assert on either interrupt
// - ir bit 0 receive polarity, reset active high
// - ir bit 1 transmit polarity, reset active low
// - ir bit 2 selects half duplex, reset full
// - ir bits 5:3 select infrared mode, reset standard
// - ir bit 6 picks uart two pins or alternate infrared pins
// - half duplex timeout in 100 us steps, reset 3
// - timeout zero blanks only during activity; each count adds 100 us
// - keyboard bit 7 sets aux output polarity, reset active low
// - keyboard bit 2 enables port 92, reset 0
// - keyboard indexes f1 to ff read zero
// - only hard reset restores defaults; soft reset ignored
//
// Strobed register access was decided locally.
`include "ldcfg_defines.svh"
`default_nettype none
module logical_device_config_regs
	import ldcfg_pkg::*;
#(
	parameter int STEP_CYC = `HD_STEP_CYC
) (
	// clock, hard reset and soft reset
	input wire logic clk,
	input wire logic reset,
	input wire logic soft_reset,
	// register port
	input wire reg_req_type req,
	output logic [7:0] rdata,
	// static configuration
	output pp_cfg_type pp_cfg,
	output misc_cfg_type misc_cfg,
	// parallel port interrupt
	input wire logic [2:0] ecr_mode,
	input wire logic pp_irq_event,
	input wire logic pp_irq_level,
	input wire logic pp_ack_n,
	output logic pp_irq_out,
	output logic pp_irq_oe,
	// uart interrupts
	input wire logic uart_one_irq_req,
	input wire logic uart_two_irq_req,
	output logic uart_one_irq,
	output logic uart_two_irq,
	// infrared
	input wire logic ir_tx_data,
	input wire logic ir_active,
	input wire logic uart_two_receive_pin,
	input wire logic alt_infrared_receive_pin,
	output logic ir_rx_data,
	output logic uart_two_transmit_pin,
	output logic alt_infrared_transmit_pin,
	output logic ir_blank,
	// keyboard controller
	input wire logic kbc_aux_request,
	output logic kbc_aux_output_line
);

	logic [7:0] pp_mode_r, pp_mux_r, uart_one_r, uart_two_r;
	logic [7:0] ir_opt_r, ir_tmo_r, kbd_r;
	logic [7:0] rdata_r, rdata_nxt;
	pp_cfg_type pp_cfg_r;
	misc_cfg_type misc_cfg_r;

	////////////////////////////////////////////////////////////////////////
	// decode
	// decode per device
	wire logic sel_pp = req.ldn == `LDN_PARALLEL;
	wire logic sel_u1 = req.ldn == `LDN_UART_ONE;
	wire logic sel_u2 = req.ldn == `LDN_UART_TWO;
	wire logic sel_kb = req.ldn == `LDN_KEYBOARD;
	wire logic hit_pp_mode = sel_pp && req.index == `IDX_F0;
	wire logic hit_pp_mux = sel_pp && req.index == `IDX_F1;
	wire logic hit_u1 = sel_u1 && req.index == `IDX_F0;
	wire logic hit_u2 = sel_u2 && req.index == `IDX_F0;
	wire logic hit_ir_opt = sel_u2 && req.index == `IDX_F1;
	wire logic hit_ir_tmo = sel_u2 && req.index == `IDX_F2;
	wire logic hit_kbd = sel_kb && req.index == `IDX_F0;

	// reserved keyboard indexes and unmapped fall to zero
	assign rdata_nxt = !req.rd ? 8'h00 :
		hit_pp_mode ? pp_mode_r :
		hit_pp_mux ? pp_mux_r :
		hit_u1 ? uart_one_r :
		hit_u2 ? uart_two_r :
		hit_ir_opt ? ir_opt_r :
		hit_ir_tmo ? ir_tmo_r :
		hit_kbd ? kbd_r : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// register file
	// soft reset deliberately unused; only the hard reset clears
	always_ff @(posedge clk) begin
		if (reset) begin
			pp_mode_r <= `RST_PP_MODE;
			pp_mux_r <= `RST_PP_MUX;
			uart_one_r <= `RST_UART_MODE;
			uart_two_r <= `RST_UART_MODE;
			ir_opt_r <= `RST_IR_OPTION;
			ir_tmo_r <= `RST_IR_TIMEOUT;
			kbd_r <= `RST_KBD_GATE;
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
			if (req.wr && hit_pp_mode)
				pp_mode_r <= req.wdata;
			if (req.wr && hit_pp_mux)
				pp_mux_r <= req.wdata & `MSK_PP_MUX;
			if (req.wr && hit_u1)
				uart_one_r <= req.wdata & `MSK_UART_ONE;
			if (req.wr && hit_u2)
				uart_two_r <= req.wdata & `MSK_UART_TWO;
			if (req.wr && hit_ir_opt)
				ir_opt_r <= req.wdata & `MSK_IR_OPTION;
			if (req.wr && hit_ir_tmo)
				ir_tmo_r <= req.wdata;
			if (req.wr && hit_kbd)
				kbd_r <= req.wdata & `MSK_KBD_GATE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// static fields
	pp_cfg_type pp_cfg_nxt;
	misc_cfg_type misc_cfg_nxt;
	assign pp_cfg_nxt.pp_mode = pp_mode_r[`PP_MODE_LSB +: 3];
	assign pp_cfg_nxt.fifo_threshold = pp_mode_r[`PP_THR_LSB +: 4];
	assign pp_cfg_nxt.pp_irq_pulsed = pp_mode_r[`PP_IRQ_TYPE_BIT];
	// drive mux decode; code 11 leaves the port normal
	assign pp_cfg_nxt.one_drive_on_parallel = pp_mux_r[1:0] == 2'h1;
	assign pp_cfg_nxt.two_drives_on_parallel = pp_mux_r[1:0] == 2'h2;
	assign misc_cfg_nxt.midi_one = uart_one_r[`UART_MIDI_BIT];
	assign misc_cfg_nxt.midi_two = uart_two_r[`UART_MIDI_BIT];
	assign misc_cfg_nxt.high_speed_one = uart_one_r[`UART_HS_BIT];
	assign misc_cfg_nxt.high_speed_two = uart_two_r[`UART_HS_BIT];
	assign misc_cfg_nxt.ir_mode = ir_opt_r[`IR_MODE_LSB +: 3];
	assign misc_cfg_nxt.ir_half_duplex = ir_opt_r[`IR_DUPLEX_BIT];
	assign misc_cfg_nxt.port92_enable = kbd_r[`KBD_PORT92_BIT];

	////////////////////////////////////////////////////////////////////////
	// parallel port interrupt pin
	pp_irq_state_type pi_state_r, pi_state_nxt;
	logic [3:0] pi_cnt_r;
	logic pp_irq_out_r, pp_irq_oe_r;
	wire logic [2:0] ppm = pp_mode_r[`PP_MODE_LSB +: 3];
	// type bit ignored in printer and standard modes
	wire logic type_valid = ppm != `PPM_PRINTER && ppm != `PPM_SPP;
	wire logic use_pulse = type_valid && pp_mode_r[`PP_IRQ_TYPE_BIT];
	wire logic ecp_family = ppm[1];
	// fifo, ecp and test modes give a level interrupt
	wire logic ecr_level = ecp_family &&
		(ecr_mode == `ECR_FIFO || ecr_mode == `ECR_ECP || ecr_mode == `ECR_TEST);
	wire logic pulse_done = pi_cnt_r == `PP_PULSE_CYC - 4'h1;

	always_comb begin
		pi_state_nxt = pi_state_r;
		case (pi_state_r)
			PI_IDLE: if (use_pulse && pp_irq_event) pi_state_nxt = PI_PULSE;
			PI_PULSE: if (pulse_done) pi_state_nxt = PI_IDLE;
			default: pi_state_nxt = PI_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pi_state_r <= PI_IDLE;
			pi_cnt_r <= 4'h0;
			pp_irq_out_r <= 1'b1;
			pp_irq_oe_r <= 1'b0;
		end else begin
			pi_state_r <= pi_state_nxt;
			pi_cnt_r <= (pi_state_r == PI_PULSE) ? pi_cnt_r + 4'h1 : 4'h0;
			if (use_pulse) begin
				pp_irq_out_r <= 1'b0;
				pp_irq_oe_r <= pi_state_nxt == PI_PULSE;
			end else if (ecr_level) begin
				pp_irq_out_r <= pp_irq_level;
				pp_irq_oe_r <= 1'b1;
			end else begin
				pp_irq_out_r <= pp_ack_n;
				pp_irq_oe_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// uart interrupt sharing
	// share bit merges the two requests
	// both lines assert; software keeps one unassigned
	wire logic share = uart_one_r[`UART_SHARE_BIT];
	wire logic any_uart = uart_one_irq_req || uart_two_irq_req;
	logic uart_one_irq_r, uart_two_irq_r;

	////////////////////////////////////////////////////////////////////////
	// infrared routing and polarity
	// location mux
	wire logic ir_alt = ir_opt_r[`IR_LOC_BIT];
	wire logic rx_pin = ir_alt ? alt_infrared_receive_pin : uart_two_receive_pin;
	wire logic rx_val = rx_pin ^ ir_opt_r[`IR_RX_POL_BIT];
	// transmit polarity; idle pin rests at its inactive level
	wire logic tx_pol = ir_opt_r[`IR_TX_POL_BIT];
	wire logic tx_val = ir_tx_data ^ tx_pol;
	logic ir_rx_r, u2_tx_r, alt_tx_r;

	////////////////////////////////////////////////////////////////////////
	// half duplex blanking
	// hold counter is 8 bits of 100 us steps; long waits use a parameter
	logic [7:0] hd_left_r;
	logic [15:0] hd_sub_r;
	logic ir_blank_r;
	wire logic step_end = hd_sub_r == 16'(STEP_CYC - 1);
	wire logic half = ir_opt_r[`IR_DUPLEX_BIT];

	always_ff @(posedge clk) begin
		if (reset) begin
			hd_left_r <= 8'h00;
			hd_sub_r <= 16'h0000;
			ir_blank_r <= 1'b0;
		end else begin
			// reload the timeout after each active cycle
			if (ir_active) begin
				hd_left_r <= ir_tmo_r;
				hd_sub_r <= 16'h0000;
			end else if (hd_left_r != 8'h00) begin
				hd_sub_r <= step_end ? 16'h0000 : hd_sub_r + 16'h0001;
				if (step_end)
					hd_left_r <= hd_left_r - 8'h01;
			end
			ir_blank_r <= half && (ir_active || hd_left_r != 8'h00);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output flops
	logic kbc_aux_r;
	// fields reset to the register's own reset so no false mode shows at release
	localparam logic [7:0] PP_RST = `RST_PP_MODE;
	localparam pp_cfg_type PP_CFG_RST = {PP_RST[2:0], PP_RST[6:3], PP_RST[7], 2'b00};
	always_ff @(posedge clk) begin
		if (reset) begin
			pp_cfg_r <= PP_CFG_RST;
			misc_cfg_r <= '0;
			uart_one_irq_r <= 1'b0;
			uart_two_irq_r <= 1'b0;
			ir_rx_r <= 1'b0;
			u2_tx_r <= 1'b0;
			alt_tx_r <= 1'b0;
			kbc_aux_r <= 1'b1;
		end else begin
			pp_cfg_r <= pp_cfg_nxt;
			misc_cfg_r <= misc_cfg_nxt;
			uart_one_irq_r <= share ? any_uart : uart_one_irq_req;
			uart_two_irq_r <= share ? any_uart : uart_two_irq_req;
			ir_rx_r <= rx_val;
			u2_tx_r <= ir_alt ? tx_pol : tx_val;
			alt_tx_r <= ir_alt ? tx_val : tx_pol;
			kbc_aux_r <= kbd_r[`KBD_AUX_POL_BIT] ? kbc_aux_request : !kbc_aux_request;
		end
	end

	assign rdata = rdata_r;
	assign pp_cfg = pp_cfg_r;
	assign misc_cfg = misc_cfg_r;
	assign pp_irq_out = pp_irq_out_r;
	assign pp_irq_oe = pp_irq_oe_r;
	assign uart_one_irq = uart_one_irq_r;
	assign uart_two_irq = uart_two_irq_r;
	assign ir_rx_data = ir_rx_r;
	assign uart_two_transmit_pin = u2_tx_r;
	assign alt_infrared_transmit_pin = alt_tx_r;
	assign ir_blank = ir_blank_r;
	assign kbc_aux_output_line = kbc_aux_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_PP_MODE_FIELD: assert property (@(posedge clk) disable iff (reset)
		pp_cfg.pp_mode == $past(pp_mode_r[2:0])) else $error("mode field wrong");
	AST_READ_BACK: assert property (@(posedge clk) disable iff (reset)
		req.wr && hit_u1 ##1 req.rd && hit_u1 |=> rdata == ($past(req.wdata, 2) & 8'h83))
		else $error("uart one readback wrong");
	AST_KBD_RSVD: assert property (@(posedge clk) disable iff (reset)
		req.rd && sel_kb && req.index >= 8'hf1 |=> rdata == 8'h00)
		else $error("reserved read not zero");
	AST_PULSE_RELEASE: assert property (@(posedge clk) disable iff (reset)
		$rose(pp_irq_oe) && use_pulse |-> !pp_irq_out ##2 !pp_irq_oe)
		else $error("pulse not released");
	AST_ACK_FOLLOW: assert property (@(posedge clk) disable iff (reset)
		!use_pulse && !ecr_level && !$past(use_pulse) |=> pp_irq_oe && pp_irq_out == $past(pp_ack_n))
		else $error("interrupt not following ack");
	AST_SHARE_BOTH: assert property (@(posedge clk) disable iff (reset)
		share && uart_two_irq_req |=> uart_one_irq && uart_two_irq)
		else $error("shared interrupt not on both");
	AST_AUX_POL: assert property (@(posedge clk) disable iff (reset)
		!kbd_r[7] && kbc_aux_request |=> !kbc_aux_output_line)
		else $error("aux polarity wrong");
	AST_BLANK_ZERO: assert property (@(posedge clk) disable iff (reset)
		half && ir_tmo_r == 8'h00 && $fell(ir_active) ##1 !ir_active |=> !ir_blank)
		else $error("blank outlasted activity");
	AST_FULL_NO_BLANK: assert property (@(posedge clk) disable iff (reset)
		!half |=> !ir_blank) else $error("blank in full duplex");
	AST_MODE_WRITE: assert property (@(posedge clk) disable iff (reset)
		req.wr && hit_pp_mode |=> pp_mode_r == $past(req.wdata))
		else $error("mode register not written");
	AST_THRESHOLD: assert property (@(posedge clk) disable iff (reset)
		pp_cfg.fifo_threshold == $past(pp_mode_r[6:3]))
		else $error("threshold field wrong");
	AST_PULSE_LOW: assert property (@(posedge clk) disable iff (reset)
		use_pulse |=> !pp_irq_out)
		else $error("pulse level not low");
	AST_LEVEL_IRQ: assert property (@(posedge clk) disable iff (reset)
		!use_pulse && ecr_level |=> pp_irq_oe && pp_irq_out == $past(pp_irq_level))
		else $error("level interrupt wrong");
	AST_TYPE_IGNORED: assert property (@(posedge clk) disable iff (reset)
		!type_valid |=> pp_irq_oe)
		else $error("type bit not ignored");
	AST_MUX_ONE: assert property (@(posedge clk) disable iff (reset)
		pp_mux_r[1:0] == 2'h1 |=> pp_cfg.one_drive_on_parallel && !pp_cfg.two_drives_on_parallel)
		else $error("one drive mux wrong");
	AST_MUX_TWO: assert property (@(posedge clk) disable iff (reset)
		pp_mux_r[1:0] == 2'h2 |=> pp_cfg.two_drives_on_parallel && !pp_cfg.one_drive_on_parallel)
		else $error("two drive mux wrong");
	AST_MIDI: assert property (@(posedge clk) disable iff (reset)
		misc_cfg.midi_one == $past(uart_one_r[0]) && misc_cfg.midi_two == $past(uart_two_r[0]))
		else $error("midi enable wrong");
	AST_HIGH_SPEED: assert property (@(posedge clk) disable iff (reset)
		misc_cfg.high_speed_one == $past(uart_one_r[1]) &&
		misc_cfg.high_speed_two == $past(uart_two_r[1])) else $error("high speed enable wrong");
	AST_SHARE_OFF: assert property (@(posedge clk) disable iff (reset)
		!share |=> uart_one_irq == $past(uart_one_irq_req) && uart_two_irq == $past(uart_two_irq_req))
		else $error("separate interrupts wrong");
	AST_RX_POL: assert property (@(posedge clk) disable iff (reset)
		!ir_alt && !ir_opt_r[0] |=> ir_rx_data == $past(uart_two_receive_pin))
		else $error("receive polarity wrong");
	AST_TX_IDLE: assert property (@(posedge clk) disable iff (reset)
		!ir_alt |=> alt_infrared_transmit_pin == $past(ir_opt_r[1]))
		else $error("unused transmit pin not idle");
	AST_HALF_FLAG: assert property (@(posedge clk) disable iff (reset)
		misc_cfg.ir_half_duplex == $past(ir_opt_r[2]))
		else $error("duplex flag wrong");
	AST_IR_MODE: assert property (@(posedge clk) disable iff (reset)
		misc_cfg.ir_mode == $past(ir_opt_r[5:3]))
		else $error("infrared mode wrong");
	AST_ALT_TX: assert property (@(posedge clk) disable iff (reset)
		ir_alt && !ir_opt_r[1] |=> alt_infrared_transmit_pin == $past(ir_tx_data))
		else $error("alternate transmit wrong");
	AST_BLANK_HOLD: assert property (@(posedge clk) disable iff (reset)
		half && $fell(ir_active) && ir_tmo_r != 8'h00 |=> ir_blank)
		else $error("blank dropped early");
	AST_AUX_HIGH: assert property (@(posedge clk) disable iff (reset)
		kbd_r[7] && kbc_aux_request |=> kbc_aux_output_line)
		else $error("aux high polarity wrong");
	AST_PORT92: assert property (@(posedge clk) disable iff (reset)
		misc_cfg.port92_enable == $past(kbd_r[2]))
		else $error("port 92 enable wrong");
	AST_SOFT_KEEP: assert property (@(posedge clk) disable iff (reset)
		soft_reset && !req.wr |=> $stable(pp_mode_r) && $stable(kbd_r) && $stable(ir_opt_r))
		else $error("soft reset changed a register");
endmodule
`default_nettype wire

// ==== shared/ldcfg_defines.svh ====
`ifndef LDCFG_DEFINES_SVH
`define LDCFG_DEFINES_SVH

// logical device numbers
`define LDN_PARALLEL 8'h03
`define LDN_UART_ONE 8'h04
`define LDN_UART_TWO 8'h05
`define LDN_KEYBOARD 8'h07

// register indexes
`define IDX_F0 8'hf0
`define IDX_F1 8'hf1
`define IDX_F2 8'hf2
`define IDX_KBD_RSVD_LO 8'hf1
`define IDX_KBD_RSVD_HI 8'hff

// reset values
`define RST_PP_MODE 8'h3c
`define RST_PP_MUX 8'h00
`define RST_UART_MODE 8'h00
`define RST_IR_OPTION 8'h02
`define RST_IR_TIMEOUT 8'h03
`define RST_KBD_GATE 8'h00

// implemented bits; the rest read zero
`define MSK_PP_MUX 8'h03
`define MSK_UART_ONE 8'h83
`define MSK_UART_TWO 8'h03
`define MSK_IR_OPTION 8'h7f
`define MSK_KBD_GATE 8'h84

// field positions
`define PP_MODE_LSB 0
`define PP_THR_LSB 3
`define PP_IRQ_TYPE_BIT 7
`define UART_MIDI_BIT 0
`define UART_HS_BIT 1
`define UART_SHARE_BIT 7
`define IR_RX_POL_BIT 0
`define IR_TX_POL_BIT 1
`define IR_DUPLEX_BIT 2
`define IR_MODE_LSB 3
`define IR_LOC_BIT 6
`define KBD_PORT92_BIT 2
`define KBD_AUX_POL_BIT 7

// parallel port modes and extended-control modes
`define PPM_SPP 3'h0
`define PPM_PRINTER 3'h4
`define PPM_ECP 3'h2
`define ECR_FIFO 3'h2
`define ECR_ECP 3'h3
`define ECR_TEST 3'h6

// timing
`define CLK_HZ 50000000
`define HD_STEP_US 100
`define HD_STEP_CYC ((`CLK_HZ / 1000000) * `HD_STEP_US)
`define PP_PULSE_CYC 4'h2

`endif

// ==== shared/ldcfg_pkg.sv ====
`default_nettype none
package ldcfg_pkg;
	typedef struct packed {
		logic [7:0] ldn;
		logic [7:0] index;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;

	typedef struct packed {
		logic [2:0] pp_mode;
		logic [3:0] fifo_threshold;
		logic pp_irq_pulsed;
		logic one_drive_on_parallel;
		logic two_drives_on_parallel;
	} pp_cfg_type;

	typedef struct packed {
		logic midi_one;
		logic high_speed_one;
		logic midi_two;
		logic high_speed_two;
		logic [2:0] ir_mode;
		logic ir_half_duplex;
		logic port92_enable;
	} misc_cfg_type;

	typedef enum logic {PI_IDLE, PI_PULSE} pp_irq_state_type;
endpackage
`default_nettype wire

// ==== tb/logical_device_config_regs_test.sv ====
`include "ldcfg_defines.svh"
`default_nettype none
module logical_device_config_regs_test
	import ldcfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// short blanking step keeps the run small
	localparam int STEP = 4;
	logic clk, reset, soft_reset;
	reg_req_type req;
	logic [7:0] rdata;
	pp_cfg_type pp_cfg;
	misc_cfg_type misc_cfg;
	logic [2:0] ecr_mode;
	logic pp_irq_event, pp_irq_level, pp_ack_n, pp_irq_out, pp_irq_oe;
	logic u1_req, u2_req, u1_irq, u2_irq;
	logic ir_tx_data, ir_active, u2_rx, alt_rx, ir_rx_data, u2_tx, alt_tx, ir_blank;
	logic kbc_req, kbc_aux;
	int num_errors, total_checks;
	logic [2:0] modes [7] = '{3'h4, 3'h0, 3'h1, 3'h5, 3'h2, 3'h3, 3'h7};
	logic [2:0] ecrs [3] = '{3'h2, 3'h3, 3'h6};

	logical_device_config_regs #(.STEP_CYC(STEP)) dut_u (.clk(clk), .reset(reset),
		.soft_reset(soft_reset), .req(req), .rdata(rdata), .pp_cfg(pp_cfg),
		.misc_cfg(misc_cfg), .ecr_mode(ecr_mode), .pp_irq_event(pp_irq_event),
		.pp_irq_level(pp_irq_level), .pp_ack_n(pp_ack_n), .pp_irq_out(pp_irq_out),
		.pp_irq_oe(pp_irq_oe), .uart_one_irq_req(u1_req), .uart_two_irq_req(u2_req),
		.uart_one_irq(u1_irq), .uart_two_irq(u2_irq), .ir_tx_data(ir_tx_data),
		.ir_active(ir_active), .uart_two_receive_pin(u2_rx),
		.alt_infrared_receive_pin(alt_rx), .ir_rx_data(ir_rx_data),
		.uart_two_transmit_pin(u2_tx), .alt_infrared_transmit_pin(alt_tx),
		.ir_blank(ir_blank), .kbc_aux_request(kbc_req), .kbc_aux_output_line(kbc_aux));

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] ldn, idx, d);
		@(posedge clk);
		req.ldn <= ldn;
		req.index <= idx;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// rdata stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] ldn, idx, exp);
		@(posedge clk);
		req.ldn <= ldn;
		req.index <= idx;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// write then read on the very next edge, no gap
	task automatic wr_rd(input logic [7:0] ldn, idx, d, exp);
		@(posedge clk);
		req.ldn <= ldn;
		req.index <= idx;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic pulse(input logic [7:0] e);
		@(posedge clk);
		pp_irq_event <= 1'b1;
		@(posedge clk);
		pp_irq_event <= 1'b0;
		#1;
		chk({6'h0, pp_irq_oe, pp_irq_out}, e);
		tick(1);
		chk({6'h0, pp_irq_oe, pp_irq_out}, e);
	endtask

	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
	endtask

	task automatic defaults();
		rd(`LDN_PARALLEL, 8'hf0, 8'h3c);
		rd(`LDN_PARALLEL, 8'hf1, 8'h00);
		rd(`LDN_UART_ONE, 8'hf0, 8'h00);
		rd(`LDN_UART_TWO, 8'hf0, 8'h00);
		rd(`LDN_UART_TWO, 8'hf1, 8'h02);
		rd(`LDN_UART_TWO, 8'hf2, 8'h03);
		rd(`LDN_KEYBOARD, 8'hf0, 8'h00);
		for (int i = 8'hf1; i <= 8'hff; i++) begin
			rd(`LDN_KEYBOARD, 8'(i), 8'h00);
		end
		rd(8'h06, 8'hf0, 8'h00);
		$display("test defaults done");
	endtask

	task automatic conclude();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		soft_reset = 1'b0;
		req = '0;
		ecr_mode = 3'h0;
		pp_irq_event = 1'b0;
		pp_irq_level = 1'b0;
		pp_ack_n = 1'b1;
		u1_req = 1'b0;
		u2_req = 1'b0;
		ir_tx_data = 1'b0;
		ir_active = 1'b0;
		u2_rx = 1'b0;
		alt_rx = 1'b0;
		kbc_req = 1'b0;
		num_errors = 0;
		total_checks = 0;
		do_reset();
		tick(2);
		chk({1'b0, pp_cfg.fifo_threshold, pp_cfg.pp_mode}, 8'h3c);
		defaults();
		// registers: full writes read back masked, devices kept apart
		wr(`LDN_UART_ONE, 8'hf0, 8'hff);
		rd(`LDN_UART_TWO, 8'hf0, 8'h00);
		rd(`LDN_UART_ONE, 8'hf0, 8'h83);
		wr_rd(`LDN_UART_ONE, 8'hf0, 8'h7f, 8'h03);
		wr(`LDN_UART_TWO, 8'hf0, 8'hff);
		rd(`LDN_UART_TWO, 8'hf0, 8'h03);
		wr(`LDN_UART_TWO, 8'hf1, 8'hff);
		rd(`LDN_UART_TWO, 8'hf1, 8'h7f);
		wr(`LDN_UART_TWO, 8'hf2, 8'hff);
		rd(`LDN_UART_TWO, 8'hf2, 8'hff);
		wr(`LDN_KEYBOARD, 8'hf0, 8'hff);
		rd(`LDN_KEYBOARD, 8'hf0, 8'h84);
		wr(`LDN_KEYBOARD, 8'hf5, 8'hff);
		rd(`LDN_KEYBOARD, 8'hf5, 8'h00);
		rd(`LDN_PARALLEL, 8'hf0, 8'h3c);
		chk({4'h0, misc_cfg.midi_one, misc_cfg.high_speed_one, misc_cfg.midi_two,
			misc_cfg.high_speed_two}, 8'h0f);
		chk({7'h0, misc_cfg.port92_enable}, 8'h01);
		$display("test masks done");
		// mode codes and threshold field
		for (int i = 0; i < 7; i++) begin
			wr(`LDN_PARALLEL, 8'hf0, {1'b0, 4'(i + 8), modes[i]});
			tick(2);
			chk({1'b0, pp_cfg.fifo_threshold, pp_cfg.pp_mode}, {1'b0, 4'(i + 8), modes[i]});
		end
		for (int i = 0; i < 3; i++) begin
			wr(`LDN_PARALLEL, 8'hf1, 8'(i));
			wr(`LDN_UART_TWO, 8'hf1, {2'b00, 3'(i), 3'b010});
			tick(2);
			chk({6'h0, pp_cfg.two_drives_on_parallel, pp_cfg.one_drive_on_parallel}, 8'(i));
			chk({5'h0, misc_cfg.ir_mode}, 8'(i));
		end
		$display("test modes done");
		// parallel interrupt: pulse, ignored type bit, acknowledge, level
		wr(`LDN_PARALLEL, 8'hf0, 8'h82);
		tick(2);
		chk({7'h0, pp_cfg.pp_irq_pulsed}, 8'h01);
		pulse(8'h02);
		tick(1);
		chk({7'h0, pp_irq_oe}, 8'h00);
		wr(`LDN_PARALLEL, 8'hf0, 8'hbc);
		tick(2);
		pulse(8'h03);
		wr(`LDN_PARALLEL, 8'hf0, 8'h01);
		@(posedge clk);
		pp_ack_n <= 1'b0;
		tick(2);
		chk({6'h0, pp_irq_oe, pp_irq_out}, 8'h02);
		wr(`LDN_PARALLEL, 8'hf0, 8'h02);
		@(posedge clk);
		pp_irq_level <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			ecr_mode <= ecrs[i];
			tick(2);
			chk({6'h0, pp_irq_oe, pp_irq_out}, 8'h03);
		end
		@(posedge clk);
		ecr_mode <= 3'h0;
		tick(2);
		chk({6'h0, pp_irq_oe, pp_irq_out}, 8'h02);
		$display("test parallel irq done");
		// shared uart interrupt
		wr(`LDN_UART_ONE, 8'hf0, 8'h00);
		@(posedge clk);
		u1_req <= 1'b1;
		tick(2);
		chk({6'h0, u1_irq, u2_irq}, 8'h02);
		wr(`LDN_UART_ONE, 8'hf0, 8'h80);
		tick(2);
		chk({6'h0, u1_irq, u2_irq}, 8'h03);
		@(posedge clk);
		u1_req <= 1'b0;
		u2_req <= 1'b1;
		tick(2);
		chk({6'h0, u1_irq, u2_irq}, 8'h03);
		$display("test uart irq done");
		// infrared polarity, pin choice, blanking
		do_reset();
		@(posedge clk);
		ir_tx_data <= 1'b1;
		u2_rx <= 1'b1;
		alt_rx <= 1'b1;
		tick(3);
		chk({5'h0, ir_rx_data, u2_tx, alt_tx}, 8'h05);
		wr(`LDN_UART_TWO, 8'hf1, 8'h41);
		tick(3);
		chk({5'h0, ir_rx_data, u2_tx, alt_tx}, 8'h01);
		wr(`LDN_UART_TWO, 8'hf1, 8'h06);
		@(posedge clk);
		ir_active <= 1'b1;
		tick(3);
		chk({6'h0, misc_cfg.ir_half_duplex, ir_blank}, 8'h03);
		@(posedge clk);
		ir_active <= 1'b0;
		tick(2 * STEP + 2);
		chk({7'h0, ir_blank}, 8'h01);
		tick(8);
		chk({7'h0, ir_blank}, 8'h00);
		wr(`LDN_UART_TWO, 8'hf2, 8'h00);
		@(posedge clk);
		ir_active <= 1'b1;
		tick(2);
		@(posedge clk);
		ir_active <= 1'b0;
		tick(3);
		chk({7'h0, ir_blank}, 8'h00);
		wr(`LDN_UART_TWO, 8'hf1, 8'h02);
		@(posedge clk);
		ir_active <= 1'b1;
		tick(3);
		chk({7'h0, ir_blank}, 8'h00);
		$display("test infrared done");
		// keyboard aux polarity
		@(posedge clk);
		kbc_req <= 1'b1;
		tick(2);
		chk({7'h0, kbc_aux}, 8'h00);
		wr(`LDN_KEYBOARD, 8'hf0, 8'h80);
		tick(2);
		chk({7'h0, kbc_aux}, 8'h01);
		$display("test keyboard done");
		// soft reset leaves values, hard reset restores them
		wr(`LDN_PARALLEL, 8'hf0, 8'h55);
		@(posedge clk);
		soft_reset <= 1'b1;
		tick(3);
		@(posedge clk);
		soft_reset <= 1'b0;
		rd(`LDN_PARALLEL, 8'hf0, 8'h55);
		do_reset();
		defaults();
		$display("test resets done");
		conclude();
	end

	initial begin
		repeat (8000) @(posedge clk);
		num_errors++;
		conclude();
	end
endmodule
`default_nettype wire
